// file: logic/serb_defs.vh
/*
 Constants for the per-socket extended register bank: host register indices,
 extended indices, field positions and reset values.
 Assumes inclusion by bare name from the bank modules.
*/
`ifndef SERB_DEFS_VH
`define SERB_DEFS_VH

// Host-visible indices
`define SERB_IDX_SELECT 8'h2E
`define SERB_IDX_WINDOW 8'h2F

// Extended indices
`define SERB_X_SCRATCH 8'h00
`define SERB_X_MASK0 8'h01
`define SERB_X_MASK1 8'h02
`define SERB_X_EXTCTL 8'h03
`define SERB_X_ACKDLY 8'h04
`define SERB_X_EXTDATA 8'h0A
`define SERB_X_EXTCTL2 8'h0B

// Extension control fields
`define SERB_EC_PWR_LOCK 0
`define SERB_EC_AUTOCLR_DIS 1
`define SERB_EC_LED_EN 2
`define SERB_EC_PULLUP_OFF 5
`define SERB_EC_DMA_LO 6
`define SERB_EC_DMA_HI 7
`define SERB_EC_WMASK 8'hE7

// DMA request pin codes
`define SERB_DMA_OFF 2'h0
`define SERB_DMA_INPUT_ACKNOWLEDGE_N 2'h1
`define SERB_DMA_WPIO16 2'h2
`define SERB_DMA_BVD2 2'h3

// Supply enable bit of power control
`define SERB_PWR_VCC_BIT 4

// Reset values
`define SERB_RST_BYTE 8'h00

`endif

// file: logic/serb_ext_regs.v
/*
 One extended register entry: an 8-bit storage cell with write mask.
 Assumes write strobe and data arrive synchronous to sys_clk.
*/
`timescale 1ns/10ps
`include "serb_defs.vh"

module serb_ext_regs #(
    parameter [7:0] WMASK = 8'hFF
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Write side
    input wire wr_en,
    input wire [7:0] wr_data,
    // Stored value
    output wire [7:0] value
);

reg [7:0] value_q;

// Unwritable bits stay at their reset value
always @(posedge sys_clk) begin
    if (reset) begin
        value_q <= `SERB_RST_BYTE;
    end else if (wr_en) begin
        value_q <= wr_data & WMASK;
    end
end

assign value = value_q;

endmodule

// file: logic/serb_window_mask.v
/*
 Host data-bus masking for card I/O reads in one socket.
 Assumes window hit signals come from the socket's I/O map decode.
*/
`timescale 1ns/10ps
`include "serb_defs.vh"

module serb_window_mask (
    // Window hits
    input wire win0_hit,
    input wire win1_hit,
    // Mask values
    input wire [7:0] mask0,
    input wire [7:0] mask1,
    // Results
    output reg [7:0] drive_en,
    output reg force_8bit
);

// Window zero takes precedence if both maps overlap
always @* begin
    drive_en = 8'hFF;
    force_8bit = 1'b0;
    if (win0_hit) begin
        drive_en = ~mask0;
        force_8bit = |mask0;
    end else if (win1_hit) begin
        drive_en = ~mask1;
        force_8bit = |mask1;
    end
end

endmodule

// file: logic/serb_bank.v
/*
 Two-socket extended register bank: per-socket select and window
 registers, data masks, extension control, power bit guard, LED and DMA
 request selection.
 Assumes host register accesses are single-cycle strobes with socket
 number and index decoded upstream, synchronous to sys_clk.
 Assumes the power control register keeps its other bits elsewhere and
 hands only the supply enable write strobe and data to this bank.
 Assumes the I/O window hit levels and the card cycle levels come from
 the socket's own map decode and cycle engine, already synchronous.
 Assumes the pull-up cells sit in the pad ring and follow pullup_en.
*/
`timescale 1ns/10ps
`include "serb_defs.vh"

//
// Behaviour
// - Per-socket select register resets to zero
// - Select value decodes to the extended registers
// - Window port reads/writes the selected register
// - Software loads select before window access
// - Mask zero bits undriven in window zero
// - Zero mask drives all card data bits
// - Any mask bit forces 8-bit transfers
// - Mask one acts on window one
// - Power lock freezes supply enable bit against software writes
// - Removal clears supply enable unless disabled
// - LED enable drives activity LED low during card cycles
// - Socket 0 pull-up bit disables pull-ups and inputs
// - DMA bits reset zero, nonzero means DMA
// - DMA code picks the request pin
// - Each socket holds its own registers
module serb_bank (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Host register access
    input wire host_sel,
    input wire host_socket,
    input wire [7:0] host_index,
    input wire host_wr,
    input wire host_rd,
    input wire [7:0] host_wdata,
    output reg [7:0] host_rdata,
    // Power control supply bit, per socket
    input wire [1:0] pwr_wr,
    input wire [1:0] pwr_vcc_wdata,
    // Supply bit state, per socket
    output wire [1:0] pwr_vcc_on,
    // Card status per socket
    input wire [1:0] card_removed,
    input wire [1:0] card_cycle_active,
    // Card I/O window decode per socket
    input wire [1:0] io_win0_hit,
    input wire [1:0] io_win1_hit,
    // Host data drive and access width, per socket
    output wire [15:0] host_data_drive_en,
    output wire [1:0] host_force_8bit,
    // Raw detect and strobe pins
    input wire [1:0] card_detect_one,
    input wire [1:0] card_detect_two,
    input wire socket_a_strobe,
    input wire socket_b_strobe,
    // Pull-up control and gated inputs
    output wire pullup_en,
    output wire [1:0] card_detect_one_q,
    output wire [1:0] card_detect_two_q,
    output wire socket_a_strobe_q,
    output wire socket_b_strobe_q,
    // Activity indicator, low while lit
    output reg activity_led_n,
    // DMA request sources per socket
    input wire [1:0] input_acknowledge_n,
    input wire [1:0] write_protect_io16_n,
    input wire [1:0] battery_voltage_speaker,
    // DMA mode and chosen request, per socket
    output wire [1:0] dma_mode,
    output wire [1:0] card_dma_request_n
);

// Decoded targets of a select value; zero stands for a reserved index
localparam [3:0] TGT_NONE = 4'h0;
localparam [3:0] TGT_SCR = 4'h1;
localparam [3:0] TGT_MASK0 = 4'h2;
localparam [3:0] TGT_MASK1 = 4'h3;
localparam [3:0] TGT_EXTCTL = 4'h4;
localparam [3:0] TGT_ACKDLY = 4'h5;
localparam [3:0] TGT_EXTDATA = 4'h6;
localparam [3:0] TGT_EXTCTL2 = 4'h7;

// Reserved indices 05h to 09h and anything past 0Bh decode to none
function [3:0] serb_decode;
    input [7:0] idx;
    begin
        case (idx)
            `SERB_X_SCRATCH: serb_decode = TGT_SCR;
            `SERB_X_MASK0: serb_decode = TGT_MASK0;
            `SERB_X_MASK1: serb_decode = TGT_MASK1;
            `SERB_X_EXTCTL: serb_decode = TGT_EXTCTL;
            `SERB_X_ACKDLY: serb_decode = TGT_ACKDLY;
            `SERB_X_EXTDATA: serb_decode = TGT_EXTDATA;
            `SERB_X_EXTCTL2: serb_decode = TGT_EXTCTL2;
            default: serb_decode = TGT_NONE;
        endcase
    end
endfunction

// Per-socket register values
wire [7:0] sel_val [0:1];
wire [7:0] scratch_val [0:1];
wire [7:0] mask0_val [0:1];
wire [7:0] mask1_val [0:1];
wire [7:0] extctl_val [0:1];
wire [7:0] ackdly_val [0:1];
wire [7:0] extdata_val [0:1];
wire [7:0] extctl2_val [0:1];

// Control fields taken out of each socket's extension control
wire [1:0] pwr_lock;
wire [1:0] autoclr_dis;
wire [1:0] led_en;
wire [1:0] pullup_off;

// Read path of the socket named by the current access
wire [7:0] rd_sel_val;
wire [3:0] rd_tgt;
reg [7:0] rd_mux;

genvar s;
generate
    for (s = 0; s < 2; s = s + 1) begin : g_sock
        // Decoded strobes of this socket
        wire wsel;
        wire wwin;
        wire [3:0] tgt;
        wire wr_scr;
        wire wr_m0;
        wire wr_m1;
        wire wr_ec;
        wire wr_ack;
        wire wr_xd;
        wire wr_ec2;
        // Supply enable and sampled request pin, one driver each
        reg vcc_q;
        reg card_dma_request_n_n_q;

        // Each socket decodes only accesses carrying its own number
        assign wsel = host_sel & host_wr & (host_socket == s)
            & (host_index == `SERB_IDX_SELECT);
        assign wwin = host_sel & host_wr & (host_socket == s)
            & (host_index == `SERB_IDX_WINDOW);
        assign tgt = serb_decode(sel_val[s]);

        // One write enable per target; a reserved select matches none
        assign wr_scr = wwin & (tgt == TGT_SCR);
        assign wr_m0 = wwin & (tgt == TGT_MASK0);
        assign wr_m1 = wwin & (tgt == TGT_MASK1);
        assign wr_ec = wwin & (tgt == TGT_EXTCTL);
        assign wr_ack = wwin & (tgt == TGT_ACKDLY);
        assign wr_xd = wwin & (tgt == TGT_EXTDATA);
        assign wr_ec2 = wwin & (tgt == TGT_EXTCTL2);

        // Select register; it picks what the window port reaches
        serb_ext_regs u_sel (
            .sys_clk(sys_clk),
            .reset(reset),
            .wr_en(wsel),
            .wr_data(host_wdata),
            .value(sel_val[s])
        );

        // Scratchpad, plain storage for software
        serb_ext_regs u_scr (
            .sys_clk(sys_clk),
            .reset(reset),
            .wr_en(wr_scr),
            .wr_data(host_wdata),
            .value(scratch_val[s])
        );

        // Data mask for I/O window zero
        serb_ext_regs u_m0 (
            .sys_clk(sys_clk),
            .reset(reset),
            .wr_en(wr_m0),
            .wr_data(host_wdata),
            .value(mask0_val[s])
        );

        // Data mask for I/O window one
        serb_ext_regs u_m1 (
            .sys_clk(sys_clk),
            .reset(reset),
            .wr_en(wr_m1),
            .wr_data(host_wdata),
            .value(mask1_val[s])
        );

        // Extension control; bits 4:3 are not writable
        // and always read back as zero
        serb_ext_regs #(.WMASK(`SERB_EC_WMASK)) u_ec (
            .sys_clk(sys_clk),
            .reset(reset),
            .wr_en(wr_ec),
            .wr_data(host_wdata),
            .value(extctl_val[s])
        );

        // Acknowledge delay, only stored here for its own timer
        serb_ext_regs u_ack (
            .sys_clk(sys_clk),
            .reset(reset),
            .wr_en(wr_ack),
            .wr_data(host_wdata),
            .value(ackdly_val[s])
        );

        // External data, only stored here for its own port logic
        serb_ext_regs u_xd (
            .sys_clk(sys_clk),
            .reset(reset),
            .wr_en(wr_xd),
            .wr_data(host_wdata),
            .value(extdata_val[s])
        );

        // Extension control two, only stored here for its users
        serb_ext_regs u_ec2 (
            .sys_clk(sys_clk),
            .reset(reset),
            .wr_en(wr_ec2),
            .wr_data(host_wdata),
            .value(extctl2_val[s])
        );

        // Control fields of this socket
        assign pwr_lock[s] = extctl_val[s][`SERB_EC_PWR_LOCK];
        assign autoclr_dis[s] = extctl_val[s][`SERB_EC_AUTOCLR_DIS];
        assign led_en[s] = extctl_val[s][`SERB_EC_LED_EN];
        assign pullup_off[s] = extctl_val[s][`SERB_EC_PULLUP_OFF];
        assign dma_mode[s] = |extctl_val[s][`SERB_EC_DMA_HI:`SERB_EC_DMA_LO];

        // Removal wins over a software write in the same cycle
        always @(posedge sys_clk) begin
            if (reset) begin
                vcc_q <= 1'b0;
            end else if (card_removed[s] & ~autoclr_dis[s]) begin
                // The lock only guards software; removal still clears
                vcc_q <= 1'b0;
            end else if (pwr_wr[s] & ~pwr_lock[s]) begin
                // A locked write is dropped silently, with no error flag
                vcc_q <= pwr_vcc_wdata[s];
            end
        end

        // Request pin choice; idle high when not in DMA mode
        always @(posedge sys_clk) begin
            if (reset) begin
                card_dma_request_n_n_q <= 1'b1;
            end else begin
                // One sampling flop only; the pins are taken as synchronous
                case (extctl_val[s][`SERB_EC_DMA_HI:`SERB_EC_DMA_LO])
                    `SERB_DMA_INPUT_ACKNOWLEDGE_N: card_dma_request_n_n_q <= input_acknowledge_n[s];
                    `SERB_DMA_WPIO16: card_dma_request_n_n_q <= write_protect_io16_n[s];
                    `SERB_DMA_BVD2: card_dma_request_n_n_q <= battery_voltage_speaker[s];
                    default: card_dma_request_n_n_q <= 1'b1;
                endcase
            end
        end

        // Host data drive and width of card I/O accesses
        serb_window_mask u_wm (
            .win0_hit(io_win0_hit[s]),
            .win1_hit(io_win1_hit[s]),
            .mask0(mask0_val[s]),
            .mask1(mask1_val[s]),
            .drive_en(host_data_drive_en[8*s+7:8*s]),
            .force_8bit(host_force_8bit[s])
        );

        // Per-socket outputs
        assign pwr_vcc_on[s] = vcc_q;
        assign card_dma_request_n[s] = card_dma_request_n_n_q;
    end
endgenerate

// Read side picks the socket first, then decodes its select value
assign rd_sel_val = sel_val[host_socket];
assign rd_tgt = serb_decode(rd_sel_val);

// Read mux: reserved indices return zero
always @* begin
    rd_mux = `SERB_RST_BYTE;
    if (host_index == `SERB_IDX_SELECT) begin
        // The select register reads back as written
        rd_mux = rd_sel_val;
    end else if (host_index == `SERB_IDX_WINDOW) begin
        // The window has no storage of its own; it shows the target
        case (rd_tgt)
            TGT_SCR: rd_mux = scratch_val[host_socket];
            TGT_MASK0: rd_mux = mask0_val[host_socket];
            TGT_MASK1: rd_mux = mask1_val[host_socket];
            TGT_EXTCTL: rd_mux = extctl_val[host_socket];
            TGT_ACKDLY: rd_mux = ackdly_val[host_socket];
            TGT_EXTDATA: rd_mux = extdata_val[host_socket];
            TGT_EXTCTL2: rd_mux = extctl2_val[host_socket];
            default: rd_mux = `SERB_RST_BYTE;
        endcase
    end
end

// Read data registered so the host sees it one cycle after the strobe
always @(posedge sys_clk) begin
    if (reset) begin
        host_rdata <= `SERB_RST_BYTE;
    end else if (host_sel & host_rd) begin
        host_rdata <= rd_mux;
    end
end

// LED is shared by both sockets; each socket's own enable gates its activity
// Registered so a one-cycle card strobe cannot glitch the pin
always @(posedge sys_clk) begin
    if (reset) begin
        activity_led_n <= 1'b1;
    end else begin
        activity_led_n <= ~|(led_en & card_cycle_active);
    end
end

// Pull-ups and inputs are chip-wide; socket 0 control governs them.
// Disabled inputs read as their idle high level so nothing toggles inside.
// Socket 1's pull-up bit is stored and read back but drives nothing.
assign pullup_en = ~pullup_off[0];
assign card_detect_one_q = pullup_off[0] ? 2'h3 : card_detect_one;
assign card_detect_two_q = pullup_off[0] ? 2'h3 : card_detect_two;
assign socket_a_strobe_q = pullup_off[0] | socket_a_strobe;
assign socket_b_strobe_q = pullup_off[0] | socket_b_strobe;

endmodule

// file: bench/serb_bank_asserts.sv
/* Port checker for the extended register bank.
   Assumes a bind onto serb_bank from the bench top. */
`timescale 1ns/10ps
module serb_bank_asserts (
    // Clock, reset and host access
    input wire sys_clk, reset, host_sel, host_socket, host_wr, host_rd,
    input wire [7:0] host_index, host_wdata, host_rdata,
    // Power and card status
    input wire [1:0] pwr_wr, pwr_vcc_wdata, pwr_vcc_on, card_removed, card_cycle_active,
    // Windows, pins and DMA
    input wire [1:0] io_win0_hit, host_force_8bit, card_detect_one_q, dma_mode,
    input wire [1:0] card_dma_request_n,
    input wire [15:0] host_data_drive_en,
    input wire pullup_en, socket_a_strobe_q, activity_led_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Shadow select per socket, so reads can be judged without the bodies
    reg [7:0] sel_q [0:1];
    wire [7:0] cur_sel = sel_q[host_socket];
    wire rsvd = (cur_sel > 8'h04 && cur_sel < 8'h0A) || cur_sel > 8'h0B;
    always @(posedge sys_clk) begin
        if (reset) begin
            sel_q[0] <= 8'h00;
            sel_q[1] <= 8'h00;
        end else if (host_sel && host_wr && host_index == 8'h2E) begin
            sel_q[host_socket] <= host_wdata;
        end
    end
    a_sel_readback: assert property (host_sel && host_rd && host_index == 8'h2E
        |=> host_rdata == $past(cur_sel)) else $error("select readback wrong");
    a_rsvd_zero: assert property (host_sel && host_rd && host_index == 8'h2F && rsvd
        |=> host_rdata == 8'h00) else $error("reserved read not zero");
    a_rdata_hold: assert property (!(host_sel && host_rd) |=> $stable(host_rdata))
        else $error("read data moved without a read");
    a_vcc_stable: assert property (!pwr_wr[0] && !card_removed[0]
        |=> $stable(pwr_vcc_on[0])) else $error("supply bit moved unasked");
    a_vcc_rise: assert property ($rose(pwr_vcc_on[0])
        |-> $past(pwr_wr[0] && pwr_vcc_wdata[0])) else $error("supply rose unasked");
    a_mask_drive: assert property (io_win0_hit[0] && !host_force_8bit[0]
        |-> host_data_drive_en[7:0] == 8'hFF) else $error("unmasked window not driven");
    a_mask_force: assert property (io_win0_hit[0] && host_data_drive_en[7:0] != 8'hFF
        |-> host_force_8bit[0]) else $error("masked window not 8-bit");
    a_pullup_off: assert property (!pullup_en
        |-> card_detect_one_q == 2'h3 && socket_a_strobe_q) else $error("inputs not disabled");
    a_led_idle: assert property (card_cycle_active == 2'h0 |=> activity_led_n)
        else $error("led lit without activity");
    a_card_dma_request_n_idle: assert property (!dma_mode[0] |=> card_dma_request_n[0])
        else $error("request seen outside dma mode");
    cover property (host_sel && host_rd && rsvd);
    cover property ($fell(pwr_vcc_on[0]));
    cover property (!activity_led_n);
endmodule

// file: bench/serb_card_model.sv
/* Card side model: shows the DMA request on the pin picked by pick.
   Assumes the bench sets pick and req_n just after a clock edge. */
`timescale 1ns/10ps
module serb_card_model (
    // Request control
    input wire [1:0] pick, req_n,
    // Card pins, one bit per socket
    output wire [1:0] input_acknowledge_n, write_protect_io16_n, battery_voltage_speaker
);
    // Unpicked pins carry the inverse, so a wrong pin choice shows
    assign input_acknowledge_n = pick == 2'h1 ? req_n : ~req_n;
    assign write_protect_io16_n = pick == 2'h2 ? req_n : ~req_n;
    assign battery_voltage_speaker = pick == 2'h3 ? req_n : ~req_n;
endmodule

// file: bench/serb_bank_tb.sv
/* Self-checking bench for the extended register bank.
   Assumes the bank, its checker and the card model are compiled first. */
`timescale 1ns/10ps
module serb_bank_tb;
    reg sys_clk = 1'h0, reset = 1'h1, host_sel = 1'h0, host_socket = 1'h0;
    reg host_wr = 1'h0, host_rd = 1'h0, socket_a_strobe = 1'h0, socket_b_strobe = 1'h0;
    reg [7:0] host_index = 8'h00, host_wdata = 8'h00, e;
    reg [1:0] pwr_wr = 2'h0, pwr_vcc_wdata = 2'h0, card_removed = 2'h0, pick = 2'h0;
    reg [1:0] card_cycle_active = 2'h0, io_win0_hit = 2'h0, io_win1_hit = 2'h0;
    reg [1:0] card_detect_one = 2'h0, card_detect_two = 2'h1, req_n = 2'h3;
    wire [7:0] host_rdata;
    wire [1:0] pwr_vcc_on, host_force_8bit, dma_mode, card_dma_request_n;
    wire [1:0] input_acknowledge_n, write_protect_io16_n, battery_voltage_speaker;
    wire [1:0] card_detect_one_q, card_detect_two_q;
    wire [15:0] host_data_drive_en;
    wire pullup_en, socket_a_strobe_q, socket_b_strobe_q, activity_led_n;
    // Pull-up enable and every gated input, in one word
    wire [6:0] pin_view = {pullup_en, card_detect_one_q, card_detect_two_q,
        socket_a_strobe_q, socket_b_strobe_q};
    integer bad_count = 0, tests_run = 0, i;
    serb_bank i_serb_bank (.*);
    serb_card_model i_serb_card_model (.*);
    // Free running clock
    always #5 sys_clk = ~sys_clk;
    task chk(input string n, input [15:0] x, input [15:0] g);
        tests_run = tests_run + 1;
        if (g !== x) begin
            bad_count = bad_count + 1;
            $display("wrong value %0s expected %h seen %h", n, x, g);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One host strobe; the next edge returns read data
    task acc(input s, input [7:0] x, input w, input [7:0] d);
        tick(1);
        host_sel = 1'h1;
        host_socket = s;
        host_index = x;
        host_wr = w;
        host_rd = !w;
        host_wdata = d;
        tick(1);
        host_sel = 1'h0;
        host_wr = 1'h0;
        host_rd = 1'h0;
    endtask
    task xw(input s, input [7:0] x, input [7:0] d);
        acc(s, 8'h2E, 1'h1, x);
        acc(s, 8'h2F, 1'h1, d);
    endtask
    task xr(input s, input [7:0] x, input [7:0] d);
        acc(s, 8'h2E, 1'h1, x);
        acc(s, 8'h2F, 1'h0, 8'h00);
        chk("window", d, host_rdata);
    endtask
    task pulse(input [1:0] w, input [1:0] d, input [1:0] r);
        tick(1);
        pwr_wr = w;
        pwr_vcc_wdata = d;
        card_removed = r;
        tick(1);
        pwr_wr = 2'h0;
        card_removed = 2'h0;
    endtask
    task t_regs;
        acc(1'h1, 8'h2E, 1'h0, 8'h00);
        chk("select", 8'h00, host_rdata);
        for (i = 0; i < 16; i = i + 1) begin
            e = (i > 4 && i < 10) || i > 11 ? 8'h00 : i == 3 ? 8'h42 : 8'h5A;
            xw(1'h0, i[7:0], 8'h5A);
            xr(1'h0, i[7:0], e);
        end
        xr(1'h1, 8'h01, 8'h00);
        xw(1'h0, 8'h03, 8'h00);
    endtask
    task t_mask;
        xw(1'h0, 8'h01, 8'h7F);
        io_win0_hit = 2'h1;
        tick(1);
        chk("drive", 16'hFF80, host_data_drive_en);
        chk("force", 2'h1, host_force_8bit);
        io_win0_hit = 2'h0;
        io_win1_hit = 2'h1;
        tick(1);
        chk("drive", 16'hFFA5, host_data_drive_en);
        xw(1'h0, 8'h02, 8'h00);
        chk("force", 2'h0, host_force_8bit);
        chk("drive", 16'hFFFF, host_data_drive_en);
        io_win1_hit = 2'h0;
    endtask
    task t_power;
        pulse(2'h1, 2'h1, 2'h0);
        xw(1'h0, 8'h03, 8'h01);
        pulse(2'h1, 2'h0, 2'h0);
        chk("vcc", 2'h1, pwr_vcc_on);
        pulse(2'h0, 2'h0, 2'h1);
        chk("vcc", 2'h0, pwr_vcc_on);
        xw(1'h0, 8'h03, 8'h02);
        pulse(2'h1, 2'h1, 2'h0);
        pulse(2'h0, 2'h0, 2'h1);
        chk("vcc", 2'h1, pwr_vcc_on);
    endtask
    task t_pins;
        xw(1'h0, 8'h03, 8'h24);
        card_cycle_active = 2'h1;
        tick(2);
        chk("led", 1'h0, activity_led_n);
        chk("pins", 7'h3F, pin_view);
        chk("strobe", 1'h1, socket_a_strobe_q);
        card_cycle_active = 2'h0;
        xw(1'h0, 8'h03, 8'h00);
        chk("pins", 7'h44, pin_view);
        for (i = 1; i < 4; i = i + 1) begin
            xw(1'h0, 8'h03, {i[1:0], 6'h00});
            pick = i[1:0];
            req_n = 2'h2;
            tick(2);
            chk("dma", 2'h3, {dma_mode[0], card_dma_request_n[0]} ^ 2'h1);
        end
        xw(1'h1, 8'h03, 8'hC0);
        req_n = 2'h1;
        tick(2);
        chk("dma1", 2'h3, {dma_mode[1], card_dma_request_n[1]} ^ 2'h1);
        xw(1'h1, 8'h03, 8'h00);
        xw(1'h0, 8'h03, 8'h00);
        tick(2);
        chk("dma", 2'h1, {dma_mode[0], card_dma_request_n[0]});
    endtask
    task final_report;
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Main sequence after a ten cycle reset
    initial begin
        tick(10);
        reset = 1'h0;
        t_regs;
        t_mask;
        t_power;
        t_pins;
        final_report;
    end
    // Hang guard
    initial begin
        #200000;
        bad_count = bad_count + 1;
        final_report;
    end
endmodule
bind serb_bank serb_bank_asserts i_serb_bank_asserts (.*);
